/* File: verilog/led_port_pwm.sv */
// Purpose: Open-drain port levels from pattern, master and intensity registers
// Assumes: Register access port is driven by a serial front end on core_clk_in
// Notes: Flip pin is asynchronous and passes a three-flop synchroniser
`timescale 1ns/10ps
`include "led_pwm_params.svh"

module led_port_pwm
   import led_pwm_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // Register access
   input wire reg_req_t reg_req_in,
   output logic [7:0] reg_rdata_out,
   // Configuration
   input wire cfg_t cfg_in,
   // Flip pin
   input wire logic flip_pin_in,
   // Open-drain ports
   output logic [15:0] port_drive_out,
   output logic [15:0] port_oe_out,
   output logic aux_drive_out,
   output logic aux_oe_out
);

   logic [7:0] phase0_low;
   logic [7:0] phase0_high;
   logic [7:0] second_phase_pattern_low;
   logic [7:0] second_phase_pattern_high;
   logic [7:0] master_aux_intensity;
   logic [7:0] port_intensity [0:7];
   logic flip_s1;
   logic flip_s2;
   logic flip_s3;
   logic flip_level;
   logic [10:0] osc_div;
   logic osc_tick;
   pwm_time_t pwm_time;
   logic [3:0] master_count;
   logic [3:0] aux_int;
   logic pwm_active;
   logic use_phase1;
   logic [16:0] phase0_bits;
   logic [16:0] phase1_bits;
   logic [16:0] sel_pattern;
   logic [3:0] eff_int [0:16];
   logic [16:0] next_drive_low;

   // Register writes
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         phase0_low <= `RST_PATTERN;
         phase0_high <= `RST_PATTERN;
         second_phase_pattern_low <= `RST_PATTERN;
         second_phase_pattern_high <= `RST_PATTERN;
         master_aux_intensity <= `RST_MASTER_AUX;
         for (int i = 0; i < 8; i++)
         begin
            port_intensity[i] <= `RST_INTENSITY;
         end
      end
      else if (reg_req_in.write)
      begin
         if (reg_req_in.addr == `REG_PHASE0_LOW)
         begin
            phase0_low <= reg_req_in.wdata;
         end
         if (reg_req_in.addr == `REG_PHASE0_HIGH)
         begin
            phase0_high <= reg_req_in.wdata;
         end
         if (reg_req_in.addr == `REG_PHASE1_LOW)
         begin
            second_phase_pattern_low <= reg_req_in.wdata;
         end
         if (reg_req_in.addr == `REG_PHASE1_HIGH)
         begin
            second_phase_pattern_high <= reg_req_in.wdata;
         end
         if (reg_req_in.addr == `REG_MASTER_AUX)
         begin
            master_aux_intensity <= reg_req_in.wdata;
         end
         if (reg_req_in.addr >= `REG_INT_FIRST && reg_req_in.addr <= `REG_INT_LAST)
         begin
            port_intensity[reg_req_in.addr[2:0]] <= reg_req_in.wdata;
         end
      end
   end

   // Register read-back
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         reg_rdata_out <= `RST_UNMAPPED;
      end
      else if (reg_req_in.addr >= `REG_INT_FIRST && reg_req_in.addr <= `REG_INT_LAST)
      begin
         reg_rdata_out <= port_intensity[reg_req_in.addr[2:0]];
      end
      else
      begin
         unique case (reg_req_in.addr)
            `REG_PHASE0_LOW: reg_rdata_out <= phase0_low;
            `REG_PHASE0_HIGH: reg_rdata_out <= phase0_high;
            `REG_PHASE1_LOW: reg_rdata_out <= second_phase_pattern_low;
            `REG_PHASE1_HIGH: reg_rdata_out <= second_phase_pattern_high;
            `REG_MASTER_AUX: reg_rdata_out <= master_aux_intensity;
            default: reg_rdata_out <= `RST_UNMAPPED;
         endcase
      end
   end

   // Flip pin synchroniser; a change counts once stages two and three agree
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         flip_s1 <= 1'b0;
         flip_s2 <= 1'b0;
         flip_s3 <= 1'b0;
         flip_level <= 1'b0;
      end
      else
      begin
         flip_s1 <= flip_pin_in;
         flip_s2 <= flip_s1;
         flip_s3 <= flip_s2;
         if (flip_s2 == flip_s3)
         begin
            flip_level <= flip_s3;
         end
      end
   end

   // Settings decode
   assign master_count = master_aux_intensity[`MASTER_MSB:`MASTER_LSB];
   assign aux_int = master_aux_intensity[`AUX_MSB:`AUX_LSB];
   assign pwm_active = master_count != 4'h0;
   assign use_phase1 = cfg_in.alt_en && (cfg_in.flip_flag ^ flip_level);
   assign phase0_bits = {cfg_in.aux_phase0, phase0_high, phase0_low};
   assign phase1_bits = {cfg_in.aux_phase1, second_phase_pattern_high, second_phase_pattern_low};
   assign sel_pattern = use_phase1 ? phase1_bits : phase0_bits;

   // Oscillator divider, held still while PWM is off
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         osc_div <= 11'h000;
         osc_tick <= 1'b0;
      end
      else if (!pwm_active)
      begin
         osc_div <= 11'h000;
         osc_tick <= 1'b0;
      end
      else if (osc_div == 11'(`OSC_DIV - 1))
      begin
         osc_div <= 11'h000;
         osc_tick <= 1'b1;
      end
      else
      begin
         osc_div <= osc_div + 11'h001;
         osc_tick <= 1'b0;
      end
   end

   // Slot and cycle counters of the 240-step period
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         pwm_time <= '0;
      end
      else if (!pwm_active)
      begin
         pwm_time <= '0;
      end
      else if (osc_tick)
      begin
         if (pwm_time.cycle == `LAST_CYCLE)
         begin
            pwm_time.cycle <= 4'h0;
            pwm_time.slot <= (pwm_time.slot == `LAST_SLOT) ? 4'h0 : pwm_time.slot + 4'h1;
         end
         else
         begin
            pwm_time.cycle <= pwm_time.cycle + 4'h1;
         end
      end
   end

   // Per-port cells
   genvar p;
   generate
      for (p = 0; p < `PORT_COUNT; p++)
      begin : g_port
         if (p < 16)
         begin : g_io
            // Global value replaces every individual nibble
            assign eff_int[p] = cfg_in.global_en ? aux_int :
               port_intensity[p / 2][(p % 2) * 4 +: 4];
         end
         else
         begin : g_aux
            assign eff_int[p] = aux_int;
         end
         port_pwm_cell u_cell
         (
            .intensity_in(eff_int[p]),
            .master_in(master_count),
            .pattern_in(sel_pattern[p]),
            .pwm_active_in(pwm_active),
            .time_in(pwm_time),
            .drive_low_out(next_drive_low[p])
         );
      end
   endgenerate

   // Registered open-drain outputs
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         port_drive_out <= 16'h0000;
         port_oe_out <= 16'h0000;
         aux_drive_out <= 1'b0;
         aux_oe_out <= 1'b0;
      end
      else
      begin
         port_drive_out <= 16'h0000;
         port_oe_out <= next_drive_low[15:0];
         aux_drive_out <= 1'b0;
         aux_oe_out <= next_drive_low[16];
      end
   end

   // Checks
   osc_stop_a: assert property (@(posedge core_clk_in)
      disable iff (rst_in) !pwm_active |=> (osc_div == 11'h000) && !osc_tick)
      else $error("oscillator runs while PWM is off");

   tick_gap_a: assert property (@(posedge core_clk_in)
      disable iff (rst_in) osc_tick |=> !osc_tick [*8])
      else $error("oscillator ticks too often");

   slot_wrap_a: assert property (@(posedge core_clk_in)
      disable iff (rst_in) pwm_active && osc_tick && pwm_time.slot == 4'he
      && pwm_time.cycle == 4'hf |=> pwm_time == '0)
      else $error("period does not wrap after slot 14");

   cycle_wrap_a: assert property (@(posedge core_clk_in)
      disable iff (rst_in) pwm_active && osc_tick && pwm_time.cycle == 4'hf
      && pwm_time.slot != 4'he |=> pwm_time.cycle == 4'h0
      && pwm_time.slot == $past(pwm_time.slot) + 4'h1)
      else $error("slot does not advance after cycle 15");

   all_static_a: assert property (@(posedge core_clk_in)
      disable iff (rst_in) !pwm_active |=> port_oe_out == ~$past(sel_pattern[15:0]))
      else $error("output not static with PWM off");

   full_static_a: assert property (@(posedge core_clk_in)
      disable iff (rst_in) pwm_active && eff_int[0] == 4'hf
      |=> port_oe_out[0] == !$past(sel_pattern[0]))
      else $error("full intensity port not static");

   slot_gate_a: assert property (@(posedge core_clk_in)
      disable iff (rst_in) pwm_active && eff_int[1] != 4'hf && pwm_time.slot >= master_count
      |=> port_oe_out[1] == $past(sel_pattern[1]))
      else $error("port active outside enabled slot");

   on_time_a: assert property (@(posedge core_clk_in)
      disable iff (rst_in) pwm_active && eff_int[2] != 4'hf && pwm_time.slot < master_count
      && pwm_time.cycle <= eff_int[2] |=> port_oe_out[2] == !$past(sel_pattern[2]))
      else $error("on-time level wrong");

   phase_sel_a: assert property (@(posedge core_clk_in)
      disable iff (rst_in) !pwm_active && cfg_in.alt_en && (cfg_in.flip_flag ^ flip_level)
      |=> port_oe_out[7:0] == ~$past(second_phase_pattern_low))
      else $error("second phase not selected");

   global_int_a: assert property (@(posedge core_clk_in)
      disable iff (rst_in) cfg_in.global_en && pwm_active && aux_int != 4'hf
      && pwm_time.slot < master_count && pwm_time.cycle > aux_int
      |=> port_oe_out[5] == $past(sel_pattern[5]))
      else $error("global intensity not applied");

   phase1_write_a: assert property (@(posedge core_clk_in)
      disable iff (rst_in) reg_req_in.write && reg_req_in.addr == 8'h0b
      |=> second_phase_pattern_high == $past(reg_req_in.wdata))
      else $error("second phase high register not written");

endmodule

/* File: verilog/led_pwm_params.svh */
// Purpose: Offsets, reset values and timing counts for the LED port PWM block
// Assumes: Included by the package users; definitions only
// Notes: Register offsets are byte addresses on the register access port
`ifndef LED_PWM_PARAMS_SVH
`define LED_PWM_PARAMS_SVH

// Register offsets
`define REG_PHASE0_LOW 8'h02
`define REG_PHASE0_HIGH 8'h03
`define REG_PHASE1_LOW 8'h0a
`define REG_PHASE1_HIGH 8'h0b
`define REG_MASTER_AUX 8'h0e
`define REG_INT_FIRST 8'h10
`define REG_INT_LAST 8'h17

// Reset values
`define RST_PATTERN 8'hff
`define RST_MASTER_AUX 8'h00
`define RST_INTENSITY 8'hff
`define RST_UNMAPPED 8'h00

// Field positions in the master/aux register
`define MASTER_MSB 7
`define MASTER_LSB 4
`define AUX_MSB 3
`define AUX_LSB 0

// PWM structure
`define INT_STATIC 4'hf
`define LAST_SLOT 4'he
`define LAST_CYCLE 4'hf
`define PORT_COUNT 17

// Oscillator timing
`define CLK_HZ 50000000
`define OSC_HZ 32000
`define OSC_DIV (`CLK_HZ / `OSC_HZ)

`endif

/* File: verilog/led_pwm_pkg.sv */
// Purpose: Types shared by the LED port PWM block
// Assumes: Nothing beyond the params header
// Notes: Holds types only
package led_pwm_pkg;

   typedef struct packed
   {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic write;
   } reg_req_t;

   typedef struct packed
   {
      logic global_en;
      logic alt_en;
      logic flip_flag;
      logic aux_phase0;
      logic aux_phase1;
   } cfg_t;

   typedef struct packed
   {
      logic [3:0] slot;
      logic [3:0] cycle;
   } pwm_time_t;

endpackage

/* File: verilog/port_pwm_cell.sv */
// Purpose: Output level of one port from its intensity, pattern bit and PWM time
// Assumes: Time and settings are stable in the core clock domain
// Notes: Purely combinational; the caller registers the result
`timescale 1ns/10ps
`include "led_pwm_params.svh"

module port_pwm_cell
   import led_pwm_pkg::*;
(
   // Settings
   input wire logic [3:0] intensity_in,
   input wire logic [3:0] master_in,
   input wire logic pattern_in,
   input wire logic pwm_active_in,
   // PWM time
   input wire pwm_time_t time_in,
   // Result
   output logic drive_low_out
);

   logic static_mode;
   logic slot_on;
   logic on_time;
   logic level;

   always_comb
   begin
      static_mode = !pwm_active_in || (intensity_in == `INT_STATIC);
      slot_on = time_in.slot < master_in;
      on_time = slot_on && (time_in.cycle <= intensity_in);
      if (static_mode)
      begin
         level = pattern_in;
      end
      else if (on_time)
      begin
         level = pattern_in;
      end
      else
      begin
         level = !pattern_in;
      end
      drive_low_out = !level;
   end

endmodule

/* File: verif/led_load_model.sv */
// Purpose: LED loads on the open-drain ports, with low-time counters
// Assumes: Pull-up on every pin, so a released pin reads high
// Notes: Index 16 is the aux output
`timescale 1ns/10ps

module led_load_model
(
   // Clock and control
   input wire logic core_clk_in,
   input wire logic clear_in,
   input wire logic count_en_in,
   // Ports from the block
   input wire logic [15:0] port_drive_in,
   input wire logic [15:0] port_oe_in,
   input wire logic aux_drive_in,
   input wire logic aux_oe_in,
   // Observations
   output logic [16:0] pin_level_out,
   output logic [16:0][15:0] low_count_out
);
   logic [16:0] oe_all;
   logic [16:0] drv_all;
   assign oe_all = {aux_oe_in, port_oe_in};
   assign drv_all = {aux_drive_in, port_drive_in};
   // Released pin pulled high
   assign pin_level_out = (oe_all & drv_all) | ~oe_all;
   always_ff @(posedge core_clk_in)
   begin
      for (int i = 0; i < 17; i++)
      begin
         if (clear_in)
            low_count_out[i] <= 16'h0000;
         else if (count_en_in && !pin_level_out[i])
            low_count_out[i] <= low_count_out[i] + 16'h0001;
      end
   end
endmodule

/* File: verif/testbench.sv */
// Purpose: Self-checking bench for the LED port PWM block
// Assumes: LED loads with pull-ups on all ports
// Notes: Low times are measured in clocks over whole slots, and once over three ticks of disabled slots
`timescale 1ns/10ps
`include "led_pwm_params.svh"

module testbench
   import led_pwm_pkg::*;
;
   localparam int TICK = `OSC_DIV;
   logic core_clk_in, rst_in, flip_pin_in, clear, count_en, aux_drive, aux_oe;
   reg_req_t reg_req;
   cfg_t cfg;
   logic [7:0] rdata;
   logic [15:0] port_drive, port_oe;
   logic [16:0] pin_level;
   logic [16:0][15:0] low_count;
   int fail_count, n_checks, cycles;

   led_port_pwm dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .reg_req_in(reg_req),
      .reg_rdata_out(rdata), .cfg_in(cfg), .flip_pin_in(flip_pin_in),
      .port_drive_out(port_drive), .port_oe_out(port_oe), .aux_drive_out(aux_drive),
      .aux_oe_out(aux_oe));
   led_load_model load (.core_clk_in(core_clk_in), .clear_in(clear), .count_en_in(count_en),
      .port_drive_in(port_drive), .port_oe_in(port_oe), .aux_drive_in(aux_drive),
      .aux_oe_in(aux_oe), .pin_level_out(pin_level), .low_count_out(low_count));

   initial
   begin
      core_clk_in = 0;
      forever #10 core_clk_in = ~core_clk_in;
   end

   task automatic close_out();
      if (fail_count == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string name, input logic [16:0] exp, input logic [16:0] got);
      n_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic chk_low(input int idx, input int exp);
      n_checks++;
      if ($isunknown(low_count[idx]) || low_count[idx] > exp + 12 || low_count[idx] + 12 < exp)
      begin
         fail_count++;
         $display("MISMATCH low_time_%0d expected %0d seen %0d", idx, exp, low_count[idx]);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk_in);
      reg_req.addr = a;
      reg_req.wdata = d;
      reg_req.write = 1'b1;
      @(negedge core_clk_in);
      reg_req.write = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
      @(negedge core_clk_in);
      reg_req.addr = a;
      @(negedge core_clk_in);
      chk(name, {9'h000, exp}, {9'h000, rdata});
   endtask

   task automatic measure(input int n);
      @(negedge core_clk_in);
      clear = 1'b1;
      @(negedge core_clk_in);
      clear = 1'b0;
      count_en = 1'b1;
      repeat (n) @(negedge core_clk_in);
      count_en = 1'b0;
   endtask

   initial
   begin
      cycles = 0;
      forever
      begin
         @(posedge core_clk_in);
         cycles++;
         if (cycles == 90000)
         begin
            fail_count++;
            close_out();
         end
      end
   end

   initial
   begin
      rst_in = 1'b1;
      reg_req = '0;
      cfg = '0;
      flip_pin_in = 1'b0;
      clear = 1'b0;
      count_en = 1'b0;
      repeat (4) @(posedge core_clk_in);
      @(negedge core_clk_in);
      rst_in = 1'b0;
      chk("oe_reset", 17'h00000, {aux_oe, port_oe});
      rd(`REG_PHASE1_LOW, 8'hff, "phase1_low");
      rd(`REG_PHASE1_HIGH, 8'hff, "phase1_high");
      rd(`REG_MASTER_AUX, 8'h00, "master_aux");
      rd(`REG_INT_FIRST, 8'hff, "int_first");
      rd(`REG_INT_LAST, 8'hff, "int_last");
      rd(8'h04, 8'h00, "unmapped");
      wr(8'h04, 8'h5a);
      rd(8'h04, 8'h00, "unmapped_wr");
      wr(`REG_PHASE1_LOW, 8'h55);
      wr(`REG_PHASE1_HIGH, 8'ha3);
      rd(`REG_PHASE1_LOW, 8'h55, "phase1_low_wr");
      rd(`REG_PHASE1_HIGH, 8'ha3, "phase1_high_wr");
      // Static outputs with PWM values that must have no effect
      wr(`REG_PHASE0_LOW, 8'h0f);
      wr(`REG_PHASE0_HIGH, 8'hf0);
      wr(`REG_INT_FIRST, 8'h00);
      wr(`REG_MASTER_AUX, 8'h0f);
      cfg.global_en = 1'b1;
      cfg.aux_phase1 = 1'b1;
      repeat (4) @(negedge core_clk_in);
      chk("pins_static", 17'h0f00f, pin_level);
      chk("oe_static", 17'h10ff0, {aux_oe, port_oe});
      cfg.global_en = 1'b0;
      cfg.alt_en = 1'b1;
      for (int k = 0; k < 4; k++)
      begin
         cfg.flip_flag = k[0];
         flip_pin_in = k[1];
         repeat (8) @(negedge core_clk_in);
         chk("pins_phase", (k[0] ^ k[1]) ? 17'h1a355 : 17'h0f00f, pin_level);
      end
      cfg.alt_en = 1'b0;
      flip_pin_in = 1'b0;
      repeat (8) @(negedge core_clk_in);
      chk("pins_no_alt", 17'h0f00f, pin_level);
      cfg.flip_flag = 1'b0;
      // Individual PWM, one enabled slot
      wr(`REG_PHASE0_LOW, 8'h08);
      wr(`REG_PHASE0_HIGH, 8'h00);
      wr(`REG_INT_FIRST, 8'he0);
      wr(8'h11, 8'h7f);
      wr(`REG_MASTER_AUX, 8'h13); // master at least 0x10
      measure(16 * TICK - 8);
      chk_low(0, TICK);
      chk_low(1, 15 * TICK);
      chk_low(2, 16 * TICK);
      chk_low(3, 8 * TICK);
      chk_low(16, 4 * TICK);
      repeat (20) @(negedge core_clk_in);
      measure(3 * TICK);
      chk_low(0, 0);
      chk_low(1, 0);
      chk_low(3, 3 * TICK);
      // Global control, two enabled slots
      wr(`REG_MASTER_AUX, 8'h00);
      cfg.global_en = 1'b1;
      wr(`REG_MASTER_AUX, 8'h25);
      measure(32 * TICK - 8);
      chk_low(0, 12 * TICK);
      chk_low(2, 12 * TICK);
      chk_low(3, 20 * TICK);
      chk_low(4, 12 * TICK);
      chk_low(16, 12 * TICK);
      chk("drive_zero", 17'h00000, {aux_drive, port_drive});
      close_out();
   end
endmodule
